/* bench/host_serial_model.sv */
`timescale 1ns/1ps
`default_nettype none
module host_serial_model (
   // System clock paces the host
   input wire logic clk_sys,
   // Serial pins
   output logic sclk_pin,
   output logic din_pin,
   output logic cs_n_pin,
   input wire logic dout_q,
   input wire logic dout_oe_n_q
);
   localparam int HALF = 4; // Above the 3-cycle synchroniser floor

   // Idle: deselected, clock parked high
   initial begin
      sclk_pin = 1'b1;
      din_pin = 1'b0;
      cs_n_pin = 1'b1;
   end

   // One framed transfer, MSB first; read bits taken on the rise
   task automatic xfer(input logic [39:0] tx, input int n, output logic [39:0] rx);
      rx = '0;
      cs_n_pin <= 1'b0;
      repeat (HALF) @(posedge clk_sys);
      for (int i = n - 1; i >= 0; i--) begin
         sclk_pin <= 1'b0;
         din_pin <= tx[i];
         repeat (HALF) @(posedge clk_sys);
         sclk_pin <= 1'b1;
         rx[i] = dout_oe_n_q ? 1'bx : dout_q;
         repeat (HALF) @(posedge clk_sys);
      end
      cs_n_pin <= 1'b1;
      din_pin <= ~tx[0]; // Released line must not look held
      repeat (HALF) @(posedge clk_sys);
   endtask
endmodule
`default_nettype wire

/* bench/sequencer_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module sequencer_asserts
   import sequencer_pkg::*;
(
   // Clock, reset, serial side and result strobe from the filter
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic cs_n_pin,
   input wire logic dout_oe_n_q,
   input wire logic result_ready_flag_n_q,
   input wire logic result_valid,
   // Converter settings
   input wire logic standby_q,
   input wire logic [1:0] channel_q,
   input wire logic [7:0] setup_q,
   input wire logic [7:0] clock_q,
   input wire logic [9:0] update_rate_q,
   // Bus and interrupt
   input wire logic [4:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   input wire logic irq_q
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   // Allowed rate for the current select code, either master clock
   logic [9:0] fast_rate, slow_rate;
   assign fast_rate = clock_q[1] ? (clock_q[0] ? RATE_F3 : RATE_F2) : (clock_q[0] ? RATE_F1 : RATE_F0);
   assign slow_rate = clock_q[1] ? (clock_q[0] ? RATE_S3 : RATE_S2) : (clock_q[0] ? RATE_S1 : RATE_S0);

   sequence s_take;
      (read || write) && waitrequest;
   endsequence
   sequence s_result;
      result_valid ##1 1'b1;
   endsequence

   property p_take_answer;
      s_take |=> !waitrequest;
   endproperty
   property p_answer_pulse;
      !waitrequest |=> waitrequest;
   endproperty
   property p_reset_vals;
      $fell(rst) |-> setup_q == SETUP_RST && clock_q == CLOCK_RST && !standby_q && channel_q == 2'h0
         && waitrequest && !irq_q && dout_oe_n_q && result_ready_flag_n_q;
   endproperty
   property p_bus_mirror;
      read && !waitrequest && (address == ADDR_SETUP || address == ADDR_CLOCK) |->
         readdata[7:0] == (address == ADDR_SETUP ? setup_q : clock_q);
   endproperty
   property p_oe_follow;
      $fell(cs_n_pin) |-> ##[1:4] !dout_oe_n_q;
   endproperty
   property p_ready_set;
      s_result |-> ##[0:2] !result_ready_flag_n_q;
   endproperty
   // Flag cannot drop while the port is deselected, nobody can read it
   property p_ready_hold;
      !result_ready_flag_n_q && cs_n_pin && $past(cs_n_pin, 4) && !result_valid |=> !result_ready_flag_n_q;
   endproperty
   property p_irq_masked;
      write && !waitrequest && address == ADDR_IRQ_MASK && writedata[IRQ_W-1:0] == 4'h0 |-> ##2 (!irq_q) [*3];
   endproperty
   property p_rate_code;
      $changed(clock_q) ##1 (!clock_q[3] && $stable(clock_q)) [*3] |->
         update_rate_q == fast_rate || update_rate_q == slow_rate;
   endproperty

   a_take_answer: assert property (p_take_answer) else $error("bus request not answered next cycle");
   a_answer_pulse: assert property (p_answer_pulse) else $error("answer longer than one cycle");
   a_reset_vals: assert property (p_reset_vals) else $error("wrong state after reset");
   a_bus_mirror: assert property (p_bus_mirror) else $error("bus read differs from register");
   a_oe_follow: assert property (p_oe_follow) else $error("output not enabled on select");
   a_ready_set: assert property (p_ready_set) else $error("ready flag not set by result");
   a_ready_hold: assert property (p_ready_hold) else $error("ready flag lost without read");
   a_irq_masked: assert property (p_irq_masked) else $error("interrupt high while masked");
   a_rate_code: assert property (p_rate_code) else $error("update rate wrong for select code");
endmodule
bind serial_register_access_sequencer sequencer_asserts sequencer_asserts_i (.clk_sys(clk_sys), .rst(rst),
   .cs_n_pin(cs_n_pin), .dout_oe_n_q(dout_oe_n_q), .result_ready_flag_n_q(result_ready_flag_n_q),
   .result_valid(result_valid), .standby_q(standby_q), .channel_q(channel_q), .setup_q(setup_q),
   .clock_q(clock_q), .update_rate_q(update_rate_q), .address(address), .read(read), .write(write),
   .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .irq_q(irq_q));
`default_nettype wire

/* bench/serial_register_access_sequencer_test.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_count++; $display("Error %0t: got %h want %h", $time, g, e); end end
module serial_register_access_sequencer_test
   import sequencer_pkg::*;
;
   logic clk_sys, rst, sclk_pin, din_pin, cs_n_pin, dout_q, dout_oe_n_q, result_ready_flag_n_q;
   logic result_valid, standby_q, read, write, waitrequest, irq_q;
   logic [15:0] result_data;
   logic [1:0] channel_q;
   logic [7:0] setup_q, clock_q;
   logic [23:0] cal_offset_q, cal_gain_q;
   logic [9:0] update_rate_q;
   logic [4:0] address;
   logic [31:0] writedata, readdata, rd;
   logic [39:0] rx;
   int err_count = 0;
   int checks_done = 0;
   logic [9:0] rates [8] = '{RATE_F0, RATE_F1, RATE_F2, RATE_F3, RATE_S0, RATE_S1, RATE_S2, RATE_S3};

   serial_register_access_sequencer serial_register_access_sequencer_i (.clk_sys(clk_sys), .rst(rst),
      .sclk_pin(sclk_pin), .din_pin(din_pin), .cs_n_pin(cs_n_pin), .dout_q(dout_q), .dout_oe_n_q(dout_oe_n_q),
      .result_ready_flag_n_q(result_ready_flag_n_q), .result_valid(result_valid), .result_data(result_data),
      .standby_q(standby_q), .channel_q(channel_q), .setup_q(setup_q), .clock_q(clock_q),
      .cal_offset_q(cal_offset_q), .cal_gain_q(cal_gain_q), .update_rate_q(update_rate_q), .address(address),
      .read(read), .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
      .irq_q(irq_q));
   host_serial_model host_serial_model_i (.clk_sys(clk_sys), .sclk_pin(sclk_pin), .din_pin(din_pin),
      .cs_n_pin(cs_n_pin), .dout_q(dout_q), .dout_oe_n_q(dout_oe_n_q));

   // 25 MHz system clock
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   task automatic end_sim;
      if (err_count == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // Control byte: start bit, target, direction, standby and channel
   function automatic logic [7:0] cb(input logic [2:0] sel, input logic dir, input logic [2:0] sb_ch);
      return {1'b0, sel, dir, sb_ch};
   endfunction

   // Bus request held until waitrequest is seen low
   task automatic bus_cycle(input logic [4:0] a, input logic wr, input logic [31:0] d);
      int n;
      n = 0;
      address <= a;
      writedata <= d;
      read <= !wr;
      write <= wr;
      do begin
         @(posedge clk_sys);
         n++;
      end while (waitrequest !== 1'b0 && n < 50);
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
      @(posedge clk_sys);
      if (n >= 50) begin
         err_count++;
         end_sim();
      end
   endtask

   // One result pulse from the filter side
   task automatic post_result(input logic [15:0] v);
      result_data <= v;
      result_valid <= 1'b1;
      @(posedge clk_sys);
      result_valid <= 1'b0;
      repeat (3) @(posedge clk_sys);
   endtask

   initial begin
      rst = 1'b1;
      read = 1'b0;
      write = 1'b0;
      address = 5'h00;
      writedata = 32'h0;
      result_valid = 1'b0;
      result_data = 16'h0;
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      `CHK(setup_q, SETUP_RST)
      `CHK(clock_q, CLOCK_RST)
      `CHK(cal_gain_q, GAIN_RST)
      `CHK({standby_q, channel_q, result_ready_flag_n_q}, 4'h1)
      bus_cycle(5'h1e, 1'b0, 32'h0);
      `CHK(rd, 32'h0)
      bus_cycle(ADDR_IRQ_STAT, 1'b1, 32'hf);
      bus_cycle(ADDR_IRQ_MASK, 1'b1, 32'h8);
      // Write then read back the setup register, back to back
      host_serial_model_i.xfer({cb(SEL_SETUP, DIR_WRITE, 3'h0), 8'ha5}, 16, rx);
      `CHK(setup_q, 8'ha5)
      host_serial_model_i.xfer({cb(SEL_SETUP, DIR_READ, 3'h0), 8'h00}, 16, rx);
      `CHK(rx[7:0], 8'ha5)
      bus_cycle(ADDR_SETUP, 1'b0, 32'h0);
      `CHK(rd[7:0], 8'ha5)
      // Control register read carries standby, channel and status
      host_serial_model_i.xfer({cb(SEL_COMM, DIR_READ, 3'h6), 8'h00}, 16, rx);
      `CHK(rx[7:0], 8'h8e)
      `CHK({standby_q, channel_q}, 3'h6)
      bus_cycle(ADDR_STATUS, 1'b0, 32'h0);
      `CHK(rd[7:0], cb(SEL_COMM, DIR_READ, 3'h6))
      // Calibration per channel
      host_serial_model_i.xfer({cb(SEL_OFFSET, DIR_WRITE, 3'h2), 24'h123456}, 32, rx);
      `CHK(cal_offset_q, 24'h123456)
      host_serial_model_i.xfer({cb(SEL_GAIN, DIR_READ, 3'h0), 24'h0}, 32, rx);
      `CHK(rx[23:0], GAIN_RST)
      `CHK(cal_offset_q, OFFSET_RST)
      // Result ready, interrupt, read out and clear
      post_result(16'hbeef);
      `CHK({result_ready_flag_n_q, irq_q}, 2'h1)
      host_serial_model_i.xfer({cb(SEL_COMM, DIR_READ, 3'h0), 8'h00}, 16, rx);
      `CHK(rx[7], 1'b0)
      host_serial_model_i.xfer({cb(SEL_DATA, DIR_READ, 3'h0), 16'h0}, 24, rx);
      `CHK(rx[15:0], 16'hbeef)
      `CHK(result_ready_flag_n_q, 1'b1)
      bus_cycle(ADDR_RESULT, 1'b0, 32'h0);
      `CHK(rd, 32'h0000beef)
      bus_cycle(ADDR_IRQ_STAT, 1'b1, 32'h8);
      @(posedge clk_sys);
      `CHK(irq_q, 1'b0)
      bus_cycle(ADDR_IRQ_MASK, 1'b1, 32'h0);
      post_result(16'h0123);
      `CHK({result_ready_flag_n_q, irq_q}, 2'h0)
      // Every rate code under both master clocks
      for (int m = 0; m < 2; m++) begin
         bus_cycle(ADDR_CONFIG, 1'b1, 32'(m));
         for (int c = 0; c < 4; c++) begin
            host_serial_model_i.xfer({cb(SEL_CLOCK, DIR_WRITE, 3'h0), 6'h01, 2'(c)}, 16, rx);
            `CHK(update_rate_q, rates[m * 4 + c])
         end
      end
      // Halving bit set: code 3 under the slow master clock at half rate
      host_serial_model_i.xfer({cb(SEL_CLOCK, DIR_WRITE, 3'h0), 6'h02, 2'h3}, 16, rx);
      `CHK(update_rate_q, RATE_S3 >> 1)
      // Lost sequence: start bit then 32 ones, then port works again
      host_serial_model_i.xfer({1'b0, 32'hffffffff}, 33, rx);
      bus_cycle(ADDR_IRQ_STAT, 1'b0, 32'h0);
      `CHK(rd[IRQ_RESYNC], 1'b1)
      host_serial_model_i.xfer({cb(SEL_SETUP, DIR_READ, 3'h0), 8'h00}, 16, rx);
      `CHK(rx[7:0], 8'ha5)
      end_sim();
   end
endmodule
`default_nettype wire

/* logic/sequencer_pkg.sv */
package sequencer_pkg;

   // Serial target codes carried in the control byte
   localparam logic [2:0] SEL_COMM = 3'h0;
   localparam logic [2:0] SEL_SETUP = 3'h1;
   localparam logic [2:0] SEL_CLOCK = 3'h2;
   localparam logic [2:0] SEL_DATA = 3'h3;
   localparam logic [2:0] SEL_TEST = 3'h4;
   localparam logic [2:0] SEL_SPARE = 3'h5;
   localparam logic [2:0] SEL_OFFSET = 3'h6;
   localparam logic [2:0] SEL_GAIN = 3'h7;

   // Register sizes in serial bits
   localparam logic [4:0] LEN_BYTE = 5'h08;
   localparam logic [4:0] LEN_DATA = 5'h10;
   localparam logic [4:0] LEN_CAL = 5'h18;

   // Direction coding of the control byte
   localparam logic DIR_WRITE = 1'h0;
   localparam logic DIR_READ = 1'h1;

   // Line-resync run length of high data bits
   localparam logic [5:0] RESYNC_RUN = 6'h20;

   // Reset values of the serial-side registers
   localparam logic [7:0] SETUP_RST = 8'h01;
   localparam logic [7:0] CLOCK_RST = 8'h05;
   localparam logic [7:0] TEST_RST = 8'h00;
   localparam logic [23:0] OFFSET_RST = 24'h1f4000;
   localparam logic [23:0] GAIN_RST = 24'h5761ab;

   // Bus register byte addresses
   localparam logic [4:0] ADDR_STATUS = 5'h00;
   localparam logic [4:0] ADDR_SETUP = 5'h04;
   localparam logic [4:0] ADDR_CLOCK = 5'h08;
   localparam logic [4:0] ADDR_IRQ_STAT = 5'h0c;
   localparam logic [4:0] ADDR_IRQ_MASK = 5'h10;
   localparam logic [4:0] ADDR_CONFIG = 5'h14;
   localparam logic [4:0] ADDR_RATE = 5'h18;
   localparam logic [4:0] ADDR_RESULT = 5'h1c;

   // Interrupt status bit positions
   localparam int IRQ_CMD = 0;
   localparam int IRQ_DONE = 1;
   localparam int IRQ_RESYNC = 2;
   localparam int IRQ_RESULT = 3;
   localparam int IRQ_W = 4;

   // Update rates in Hz per rate select code, fast and slow master clock
   localparam logic [9:0] RATE_F0 = 10'd50;
   localparam logic [9:0] RATE_F1 = 10'd60;
   localparam logic [9:0] RATE_F2 = 10'd250;
   localparam logic [9:0] RATE_F3 = 10'd500;
   localparam logic [9:0] RATE_S0 = 10'd20;
   localparam logic [9:0] RATE_S1 = 10'd25;
   localparam logic [9:0] RATE_S2 = 10'd100;
   localparam logic [9:0] RATE_S3 = 10'd200;

   // Control byte layout
   typedef struct packed {
      logic ready_n;
      logic [2:0] target_register_select;
      logic dir;
      logic standby;
      logic [1:0] channel;
   } comm_t;

   // Clock register layout
   typedef struct packed {
      logic [2:0] spare;
      logic clock_off;
      logic master_clock_halve;
      logic clock_bit;
      logic rate_select_high;
      logic rate_select_low;
   } clock_t;

   typedef enum logic [1:0] {st_cmd, st_write, st_read} serial_state_t;

endpackage

/* logic/serial_register_access_sequencer.sv */
// Added by the designer: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module serial_register_access_sequencer
   import sequencer_pkg::*;
#(
   parameter int CHANNELS = 3,
   parameter int RESULT_W = 16
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Serial pins
   input wire logic sclk_pin,
   input wire logic din_pin,
   input wire logic cs_n_pin,
   output logic dout_q,
   output logic dout_oe_n_q,
   output logic result_ready_flag_n_q,
   // Conversion results from the filter
   input wire logic result_valid,
   input wire logic [RESULT_W-1:0] result_data,
   // Settings toward the converter
   output logic standby_q,
   output logic [1:0] channel_q,
   output logic [7:0] setup_q,
   output logic [7:0] clock_q,
   output logic [23:0] cal_offset_q,
   output logic [23:0] cal_gain_q,
   output logic [9:0] update_rate_q,
   // Avalon-MM slave
   input wire logic [4:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   // Interrupt
   output logic irq_q
);

   logic sclk_m, sclk_s, sclk_d;
   logic din_m, din_s;
   logic cs_m, cs_s;
   logic sclk_rise, sclk_fall, shift_en;
   serial_state_t state_q;
   logic [4:0] bit_cnt_q;
   logic [4:0] access_len;
   logic [23:0] shift_in_q;
   logic [23:0] shift_in_d;
   logic [23:0] shift_out_q;
   logic [5:0] run_cnt_q;
   logic resync;
   comm_t comm_q;
   logic [7:0] test_q;
   logic [RESULT_W-1:0] data_q;
   logic ready_q;
   logic [23:0] offset_q [CHANNELS];
   logic [23:0] gain_q [CHANNELS];
   logic [1:0] cal_idx;
   logic ev_cmd, ev_done, ev_data_read;
   logic [IRQ_W-1:0] irq_stat_q, irq_mask_q, irq_ev;
   logic slow_mclk_q;
   logic [9:0] rate_base;
   clock_t clk_f;
   logic bus_take;
   logic [31:0] rd_mux;

   // Two-flop synchronisers on every pin; first stage feeds only the second
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sclk_m <= 1'b1;
         sclk_s <= 1'b1;
         sclk_d <= 1'b1;
         din_m <= 1'b0;
         din_s <= 1'b0;
         cs_m <= 1'b1;
         cs_s <= 1'b1;
      end else begin
         sclk_m <= sclk_pin;
         sclk_s <= sclk_m;
         sclk_d <= sclk_s;
         din_m <= din_pin;
         din_s <= din_m;
         cs_m <= cs_n_pin;
         cs_s <= cs_m;
      end
   end

   // Sample on rising serial edge, shift out on falling edge
   assign sclk_rise = sclk_s & ~sclk_d;
   assign sclk_fall = ~sclk_s & sclk_d;
   assign shift_en = sclk_rise & ~cs_s;
   assign shift_in_d = {shift_in_q[22:0], din_s};

   // Per-target length of the announced access
   always_comb begin
      case (comm_q.target_register_select)
         SEL_DATA: access_len = LEN_DATA;
         SEL_OFFSET, SEL_GAIN: access_len = LEN_CAL;
         default: access_len = LEN_BYTE;
      endcase
   end

   // Run of high data bits; a low bit restarts the count
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         run_cnt_q <= 6'h00;
      end else if (resync) begin
         run_cnt_q <= 6'h00;
      end else if (shift_en) begin
         run_cnt_q <= din_s ? run_cnt_q + 6'h01 : 6'h00;
      end
   end
   assign resync = shift_en & din_s & (run_cnt_q == RESYNC_RUN - 6'h01);

   // Access sequencer
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_q <= st_cmd;
         bit_cnt_q <= 5'h00;
         shift_in_q <= 24'h000000;
      end else if (resync) begin
         state_q <= st_cmd;
         bit_cnt_q <= 5'h00;
      end else if (shift_en) begin
         shift_in_q <= shift_in_d;
         case (state_q)
            st_cmd: begin
               // A leading one is not a start bit: wait on bit 7 for a zero
               if (bit_cnt_q == 5'h00 && din_s) begin
                  bit_cnt_q <= 5'h00;
               end else if (bit_cnt_q == LEN_BYTE - 5'h01) begin
                  bit_cnt_q <= 5'h00;
                  state_q <= (shift_in_d[3] == DIR_READ) ? st_read : st_write;
               end else begin
                  bit_cnt_q <= bit_cnt_q + 5'h01;
               end
            end
            st_write, st_read: begin
               if (bit_cnt_q == access_len - 5'h01) begin
                  bit_cnt_q <= 5'h00;
                  state_q <= st_cmd;
               end else begin
                  bit_cnt_q <= bit_cnt_q + 5'h01;
               end
            end
            default: begin
               state_q <= st_cmd;
               bit_cnt_q <= 5'h00;
            end
         endcase
      end
   end

   assign ev_cmd = shift_en & ~resync & (state_q == st_cmd) & (bit_cnt_q == LEN_BYTE - 5'h01);
   assign ev_done = shift_en & ~resync & (state_q != st_cmd) & (bit_cnt_q == access_len - 5'h01);
   assign ev_data_read = ev_done & (state_q == st_read) & (comm_q.target_register_select == SEL_DATA);

   // Control byte: target, direction, standby and channel
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         comm_q <= '0;
      end else if (ev_cmd) begin
         comm_q.target_register_select <= shift_in_d[6:4];
         comm_q.dir <= shift_in_d[3];
         comm_q.standby <= shift_in_d[2];
         comm_q.channel <= shift_in_d[1:0];
      end
   end

   // Channel index of the calibration bank, folded into range
   assign cal_idx = (int'(comm_q.channel) < CHANNELS) ? comm_q.channel : 2'h0;

   // Payload writes into the selected register
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         setup_q <= SETUP_RST;
         clock_q <= CLOCK_RST;
         test_q <= TEST_RST;
      end else if (ev_done && state_q == st_write) begin
         case (comm_q.target_register_select)
            SEL_SETUP: setup_q <= shift_in_d[7:0];
            SEL_CLOCK: clock_q <= shift_in_d[7:0];
            SEL_TEST: test_q <= shift_in_d[7:0];
            default: test_q <= test_q;
         endcase
      end
   end

   // Calibration bank, one coefficient pair per channel
   for (genvar c = 0; c < CHANNELS; c++) begin : g_cal
      always_ff @(posedge clk_sys or posedge rst) begin
         if (rst) begin
            offset_q[c] <= OFFSET_RST;
            gain_q[c] <= GAIN_RST;
         end else if (ev_done && state_q == st_write && int'(cal_idx) == c) begin
            if (comm_q.target_register_select == SEL_OFFSET) begin
               offset_q[c] <= shift_in_d;
            end
            if (comm_q.target_register_select == SEL_GAIN) begin
               gain_q[c] <= shift_in_d;
            end
         end
      end
   end

   // Result capture; a new result wins over the clearing read
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         data_q <= '0;
         ready_q <= 1'b0;
      end else if (result_valid) begin
         data_q <= result_data;
         ready_q <= 1'b1;
      end else if (ev_data_read) begin
         ready_q <= 1'b0;
      end
   end

   // Read shifter: load after the read control byte, shift on falling edges
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         shift_out_q <= 24'h000000;
         dout_q <= 1'b1;
      end else if (ev_cmd && shift_in_d[3] == DIR_READ) begin
         case (shift_in_d[6:4])
            SEL_COMM: shift_out_q <= {~ready_q, shift_in_d[6:0], 16'h0000};
            SEL_SETUP: shift_out_q <= {setup_q, 16'h0000};
            SEL_CLOCK: shift_out_q <= {clock_q, 16'h0000};
            SEL_DATA: shift_out_q <= {data_q, 8'h00};
            SEL_TEST: shift_out_q <= {test_q, 16'h0000};
            SEL_OFFSET: shift_out_q <= offset_q[cal_idx];
            SEL_GAIN: shift_out_q <= gain_q[cal_idx];
            default: shift_out_q <= 24'h000000;
         endcase
      end else if (sclk_fall && !cs_s && state_q == st_read) begin
         dout_q <= shift_out_q[23];
         shift_out_q <= {shift_out_q[22:0], 1'b0};
      end else if (state_q != st_read) begin
         dout_q <= 1'b1;
      end
   end

   // Pin-facing status and settings outputs
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         dout_oe_n_q <= 1'b1;
         result_ready_flag_n_q <= 1'b1;
         standby_q <= 1'b0;
         channel_q <= 2'h0;
         cal_offset_q <= OFFSET_RST;
         cal_gain_q <= GAIN_RST;
      end else begin
         dout_oe_n_q <= cs_s;
         result_ready_flag_n_q <= ~ready_q;
         standby_q <= comm_q.standby;
         channel_q <= comm_q.channel;
         cal_offset_q <= offset_q[cal_idx];
         cal_gain_q <= gain_q[cal_idx];
      end
   end

   // Update rate from rate select, master clock choice and halving bit
   assign clk_f = clock_t'(clock_q);
   always_comb begin
      case ({slow_mclk_q, clk_f.rate_select_high, clk_f.rate_select_low})
         3'h0: rate_base = RATE_F0;
         3'h1: rate_base = RATE_F1;
         3'h2: rate_base = RATE_F2;
         3'h3: rate_base = RATE_F3;
         3'h4: rate_base = RATE_S0;
         3'h5: rate_base = RATE_S1;
         3'h6: rate_base = RATE_S2;
         default: rate_base = RATE_S3;
      endcase
   end

   // Halving the master clock halves every rate
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         update_rate_q <= RATE_F0;
      end else begin
         update_rate_q <= clk_f.master_clock_halve ? {1'b0, rate_base[9:1]} : rate_base;
      end
   end
   // Bus handshake: one wait cycle, then a single-cycle answer
   assign bus_take = (read | write) & waitrequest;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         waitrequest <= 1'b1;
      end else begin
         waitrequest <= ~bus_take;
      end
   end
   // Read mux; unmapped addresses answer zero
   always_comb begin
      case (address)
         ADDR_STATUS: rd_mux = {21'h00000, state_q, ready_q, comm_q};
         ADDR_SETUP: rd_mux = {24'h000000, setup_q};
         ADDR_CLOCK: rd_mux = {24'h000000, clock_q};
         ADDR_IRQ_STAT: rd_mux = {28'h0000000, irq_stat_q};
         ADDR_IRQ_MASK: rd_mux = {28'h0000000, irq_mask_q};
         ADDR_CONFIG: rd_mux = {31'h00000000, slow_mclk_q};
         ADDR_RATE: rd_mux = {22'h000000, update_rate_q};
         ADDR_RESULT: rd_mux = {{(32-RESULT_W){1'b0}}, data_q};
         default: rd_mux = 32'h00000000;
      endcase
   end
   // Read data captured at the take, so it stands on the answer edge
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         readdata <= 32'h00000000;
      end else if (bus_take && read) begin
         readdata <= rd_mux;
      end
   end
   // Writes land on the answer edge, the one where the master sees waitrequest low
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         slow_mclk_q <= 1'b0;
         irq_mask_q <= '0;
      end else if (write && !waitrequest) begin
         if (address == ADDR_CONFIG) begin
            slow_mclk_q <= writedata[0];
         end
         if (address == ADDR_IRQ_MASK) begin
            irq_mask_q <= writedata[IRQ_W-1:0];
         end
      end
   end
   // Sticky events, write one to clear; a same-cycle event wins
   assign irq_ev = {result_valid, resync, ev_done, ev_cmd};
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         irq_stat_q <= '0;
      end else if (write && !waitrequest && address == ADDR_IRQ_STAT) begin
         irq_stat_q <= (irq_stat_q & ~writedata[IRQ_W-1:0]) | irq_ev;
      end else begin
         irq_stat_q <= irq_stat_q | irq_ev;
      end
   end
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(irq_stat_q & irq_mask_q);
      end
   end
endmodule
`default_nettype wire
